/* hw/sqd_pkg.sv */
// Package for the squib deployment serial command decoder.
// Assumes a 100 MHz core clock and 16-bit frames on the deploy link.
`default_nettype none
package sqd_pkg;
    // Core clock rate in MHz
    localparam int CLK_MHZ = 100;
    // Deployment period and pulse stretch period in microseconds
    localparam int DEPLOY_TIME_US = 2000;
    localparam int STRETCH_TIME_US = 7500;
    localparam int DEPLOY_CYC = DEPLOY_TIME_US * CLK_MHZ;
    localparam int STRETCH_CYC = STRETCH_TIME_US * CLK_MHZ;
    // Frame geometry
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_BITS_C = 5'h10;
    // Message field positions
    localparam int B_MODE_HI = 15;
    localparam int B_MODE_LO = 14;
    localparam int B_PARITY = 13;
    localparam int B_WRITE = 12;
    localparam int B_OR_SEL = 8;
    localparam int CFG_HI = 11;
    // Message type codes
    localparam logic [1:0] MODE_REG = 2'h0;
    localparam logic [1:0] MODE_CMD = 2'h1;
    localparam logic [1:0] MODE_DIAG = 2'h2;
    localparam logic [1:0] MODE_MON = 2'h3;
    // Fixed reply words
    localparam logic [15:0] REPLY_RESET = 16'h0000;
    localparam logic [15:0] REPLY_REG = 16'h0000;
    localparam logic [15:0] REPLY_FAULT = 16'hE000;
    // Diagnostic settings, laid out exactly as message bits 11..0
    typedef struct packed {
        logic mos_en;
        logic high_sel;
        logic cur_en;
        logic src_sel;
        logic analog_monitor_output_en;
        logic [2:0] mon_ch;
        logic cal;
        logic [2:0] cur_ch;
    } sqd_diag_cfg_t;
    localparam sqd_diag_cfg_t DIAG_RESET = '0;
    // Per-channel timer state
    typedef enum logic [1:0] {
        CH_IDLE,
        CH_STRETCH,
        CH_DEPLOY
    } sqd_ch_state_t;
endpackage : sqd_pkg
`default_nettype wire

/* hw/sqd_decoder.sv */
// Deployment serial command decoder: link shifter plus core executor.
// Assumes the host idles the link clock low, holds it still between
// frames and leaves a few core cycles after chip select rises.
`default_nettype none

// Operation
// - Top two bits select message type
// - Reply goes out in next frame
// - Odd parity over all sixteen bits
// - Command ones start deploy or stretch
// - Zero stops stretch; deployment never aborted
// - Deploying channel ignores all commands
// - Diagnostic acts only when write bit set
// - MOS diagnosis enable and side select
// - Current source enable and type select
// - Resistance currents only on exact combination
// - Low codes select current channel
// - One current channel, one monitor channel
// - Monitor bit enables analog output
// - Monitor channel selects output and comparators
// - Calibration or resistance result on output
// - Bit eight chooses status report meaning
// - OR report holds one until clear
// - Deployment status captured at select rise
// - Report follows new selection at once
// - Success flag set, blocks further deploys
// - Monitor ones clear success flags of the first NACH channels only
module sqd_decoder
    import sqd_pkg::*;
#(
    parameter int NCH = 8,
    parameter int NACH = 4,
    parameter int CW = 20,
    parameter int DEPLOY_CYCLES = DEPLOY_CYC,
    parameter int STRETCH_CYCLES = STRETCH_CYC
)(
    // Core clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Deployment link from the host
    input wire logic i_spi_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    // Loose pins from the analog side
    input wire logic i_deploy_enable,
    input wire logic [NACH-1:0] i_battery_short_threshold,
    input wire logic [NACH-1:0] i_ground_short_threshold,
    // Channel timer state
    output logic [NCH-1:0] o_deploy_active,
    output logic [NCH-1:0] o_stretch_active,
    output logic [NCH-1:0] o_deploy_success,
    // Diagnostic switches and currents, one-hot per channel
    output logic [NACH-1:0] o_low_side_switch,
    output logic [NACH-1:0] o_high_side_switch,
    output logic [NACH-1:0] o_bias_current,
    output logic [NACH-1:0] o_resistance_source_current,
    output logic [NACH-1:0] o_resistance_sink_current,
    // Analog monitor routing
    output logic o_analog_monitor_output_oe,
    output logic [NACH-1:0] o_analog_monitor_select,
    output logic o_analog_monitor_calibrate
);

    // Channel code to one-hot; codes beyond NACH select nothing
    function automatic logic [NACH-1:0] ch_decode(input logic [2:0] c);
        logic [NACH-1:0] r;
        r = '0;
        if (!c[2])
        begin
            r[c[1:0]] = 1'b1;
        end
        return r;
    endfunction

    // Odd parity holds when the count of ones is odd
    function automatic logic parity_ok(input logic [15:0] w);
        return ^w;
    endfunction

    localparam logic [CW-1:0] DEP_LOAD = CW'(DEPLOY_CYCLES - 1);
    localparam logic [CW-1:0] STR_LOAD = CW'(STRETCH_CYCLES - 1);
    // Monitor select after reset: channel 0
    localparam logic [NACH-1:0] MON_SEL_RESET = {{(NACH-1){1'b0}}, 1'b1};

    // Link domain
    logic [15:0] rx_shift_reg; // Received bits, MSB first
    logic [4:0] rx_cnt_reg; // Bits taken in this frame
    logic rx_busy_reg; // A bit of this frame already taken
    logic [15:0] tx_shift_reg; // Reply bits still to send
    logic tx_started_reg; // First reply bit already out
    logic miso_reg; // Output bit flop

    // Core domain
    logic cs_s1_reg, cs_s2_reg, cs_s3_reg; // Chip select sync
    logic den_s1_reg, den_s2_reg; // Deploy enable sync
    logic [NACH-1:0] sb_s1_reg, sb_s2_reg; // Battery short sync
    logic [NACH-1:0] sg_s1_reg, sg_s2_reg; // Ground short sync
    logic [15:0] reply_reg; // Reply for the next frame
    sqd_diag_cfg_t diag_reg; // Diagnostic settings
    logic or_sel_reg; // Status report meaning
    logic [NCH-1:0] succ_reg, succ_next; // Deploy success flags
    sqd_diag_cfg_t diag_new; // Settings once this frame is applied
    sqd_ch_state_t st_reg [NCH]; // Per-channel timer state
    logic [CW-1:0] cnt_reg [NCH]; // Per-channel countdown

    // Frame decode
    logic frame_end, frame_full, frame_ok;
    logic [1:0] mode;
    logic cmd_go, diag_go, mon_go;
    logic [NCH-1:0] deploying, dep_done;
    logic [NCH-1:0] stat_now;
    logic or_sel_next;

    // Sample MOSI on the falling link edge
    always_ff @(negedge i_spi_sclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rx_shift_reg <= '0;
        end
        else
        begin
            rx_shift_reg <= {rx_shift_reg[14:0], i_mosi};
        end
    end

    // Frame under way; select high clears it between frames
    always_ff @(negedge i_spi_sclk or posedge i_sys_rst or posedge i_cs_n)
    begin
        if (i_sys_rst || i_cs_n)
        begin
            rx_busy_reg <= 1'b0;
        end
        else
        begin
            rx_busy_reg <= 1'b1;
        end
    end

    // Count bits; the first bit of a frame restarts the count, so
    // the count still stands when the core sees select rise
    always_ff @(negedge i_spi_sclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rx_cnt_reg <= '0;
        end
        else if (!rx_busy_reg)
        begin
            rx_cnt_reg <= 5'h01;
        end
        else if (rx_cnt_reg != FRAME_BITS_C)
        begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01;
        end
    end

    // Drive the reply on rising edges; the reply word was settled
    // during the gap between frames, so it is quasi-static here
    always_ff @(posedge i_spi_sclk or posedge i_sys_rst or posedge i_cs_n)
    begin
        if (i_sys_rst || i_cs_n)
        begin
            tx_shift_reg <= '0;
            tx_started_reg <= 1'b0;
            miso_reg <= 1'b0;
        end
        else if (!tx_started_reg)
        begin
            miso_reg <= reply_reg[15];
            tx_shift_reg <= {reply_reg[14:0], 1'b0};
            tx_started_reg <= 1'b1;
        end
        else
        begin
            miso_reg <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
        end
    end

    assign o_miso = miso_reg;

    // Two-flop synchronisers; a third chip select flop finds the edge
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            den_s1_reg <= 1'b0;
            den_s2_reg <= 1'b0;
            sb_s1_reg <= '0;
            sb_s2_reg <= '0;
            sg_s1_reg <= '0;
            sg_s2_reg <= '0;
        end
        else
        begin
            cs_s1_reg <= i_cs_n;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            den_s1_reg <= i_deploy_enable;
            den_s2_reg <= den_s1_reg;
            sb_s1_reg <= i_battery_short_threshold;
            sb_s2_reg <= sb_s1_reg;
            sg_s1_reg <= i_ground_short_threshold;
            sg_s2_reg <= sg_s1_reg;
        end
    end

    // The link clock is still once select is high, so the received
    // word and count are stable when the synced edge arrives
    always_comb
    begin
        frame_end = cs_s2_reg && !cs_s3_reg;
        frame_full = (rx_cnt_reg == FRAME_BITS_C);
        mode = rx_shift_reg[B_MODE_HI:B_MODE_LO];
        // Short frame or even parity is a fault; nothing runs
        frame_ok = frame_end && frame_full
            && parity_ok(rx_shift_reg);
        cmd_go = frame_ok && (mode == MODE_CMD);
        diag_go = frame_ok && (mode == MODE_DIAG)
            && rx_shift_reg[B_WRITE];
        mon_go = frame_ok && (mode == MODE_MON);
        // A write takes effect for its own reply
        diag_new = diag_go ? sqd_diag_cfg_t'(rx_shift_reg[CFG_HI:0])
            : diag_reg;
    end

    // Deployment and completion per channel
    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            deploying[i] = (st_reg[i] == CH_DEPLOY);
            dep_done[i] = deploying[i] && (cnt_reg[i] == '0);
        end
    end

    // Per-channel timers: deployment or pulse stretch
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                st_reg[i] <= CH_IDLE;
                cnt_reg[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                case (st_reg[i])
                    CH_IDLE:
                    begin
                        // Success flag blocks a new start
                        if (cmd_go && rx_shift_reg[i]
                            && !succ_reg[i])
                        begin
                            st_reg[i] <= den_s2_reg ? CH_DEPLOY
                                : CH_STRETCH;
                            cnt_reg[i] <= den_s2_reg ? DEP_LOAD
                                : STR_LOAD;
                        end
                    end
                    CH_STRETCH:
                    begin
                        if (cmd_go && !rx_shift_reg[i])
                        begin
                            st_reg[i] <= CH_IDLE;
                        end
                        else if (cmd_go && !succ_reg[i])
                        begin
                            // Restart, or deploy if now enabled
                            st_reg[i] <= den_s2_reg ? CH_DEPLOY
                                : CH_STRETCH;
                            cnt_reg[i] <= den_s2_reg ? DEP_LOAD
                                : STR_LOAD;
                        end
                        else if (cnt_reg[i] == '0)
                        begin
                            st_reg[i] <= CH_IDLE;
                        end
                        else
                        begin
                            cnt_reg[i] <= cnt_reg[i] - 1'b1;
                        end
                    end
                    CH_DEPLOY:
                    begin
                        // Commands have no effect here at all
                        if (cnt_reg[i] == '0)
                        begin
                            st_reg[i] <= CH_IDLE;
                        end
                        else
                        begin
                            cnt_reg[i] <= cnt_reg[i] - 1'b1;
                        end
                    end
                    default:
                    begin
                        st_reg[i] <= CH_IDLE;
                    end
                endcase
            end
        end
    end

    // Success flags: expiry sets, monitor ones clear channels below NACH, set wins
    always_comb
    begin
        succ_next = succ_reg;
        for (int i = 0; i < NACH; i++)
        begin
            if (mon_go && rx_shift_reg[i])
            begin
                succ_next[i] = 1'b0;
            end
        end
        succ_next = succ_next | dep_done;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            succ_reg <= '0;
        end
        else
        begin
            succ_reg <= succ_next;
        end
    end

    // Report meaning; the new choice applies to this very reply
    always_comb
    begin
        or_sel_next = mon_go ? rx_shift_reg[B_OR_SEL] : or_sel_reg;
        // Success is set as deployment ends, so the OR has no gap;
        // deploying is read at the synced select rise
        stat_now = or_sel_next ? (deploying | succ_next)
            : succ_next;
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            or_sel_reg <= 1'b0;
        end
        else
        begin
            or_sel_reg <= or_sel_next;
        end
    end

    // Diagnostic settings change only on a valid write
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            diag_reg <= DIAG_RESET;
        end
        else if (diag_go)
        begin
            diag_reg <= sqd_diag_cfg_t'(rx_shift_reg[CFG_HI:0]);
        end
    end

    // Reply word, built at frame end and sent in the next frame
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            reply_reg <= REPLY_RESET;
        end
        else if (frame_end)
        begin
            if (!frame_ok)
            begin
                reply_reg <= REPLY_FAULT;
            end
            else
            begin
                case (mode)
                    MODE_CMD:
                    begin
                        reply_reg <= {MODE_CMD, 1'b0, den_s2_reg,
                            8'h00, rx_shift_reg[3:0]};
                    end
                    MODE_DIAG:
                    begin
                        // Comparators of the monitored channel
                        reply_reg <= {MODE_DIAG,
                            |(sb_s2_reg & ch_decode(diag_new.mon_ch)),
                            den_s2_reg, diag_new.mos_en,
                            diag_new.high_sel,
                            |(sg_s2_reg & ch_decode(diag_new.mon_ch)),
                            9'h000};
                    end
                    MODE_MON:
                    begin
                        reply_reg <= {MODE_MON, 1'b0, 8'h00,
                            or_sel_next, stat_now[3:0]};
                    end
                    default:
                    begin
                        reply_reg <= REPLY_REG;
                    end
                endcase
            end
        end
    end

    // Diagnostic drive: one current channel, one monitor channel
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_low_side_switch <= '0;
            o_high_side_switch <= '0;
            o_bias_current <= '0;
            o_resistance_source_current <= '0;
            o_resistance_sink_current <= '0;
            o_analog_monitor_output_oe <= 1'b0;
            o_analog_monitor_select <= MON_SEL_RESET;
            o_analog_monitor_calibrate <= 1'b0;
        end
        else
        begin
            o_low_side_switch <= (diag_reg.mos_en && !diag_reg.high_sel)
                ? ch_decode(diag_reg.cur_ch) : '0;
            o_high_side_switch <= (diag_reg.mos_en && diag_reg.high_sel)
                ? ch_decode(diag_reg.cur_ch) : '0;
            o_bias_current <= (diag_reg.cur_en && !diag_reg.src_sel)
                ? ch_decode(diag_reg.cur_ch) : '0;
            // MOS diagnosis keeps the resistance currents off
            o_resistance_source_current <= (diag_reg.cur_en
                && diag_reg.src_sel && !diag_reg.mos_en)
                ? ch_decode(diag_reg.cur_ch) : '0;
            o_resistance_sink_current <= (diag_reg.cur_en
                && diag_reg.src_sel && !diag_reg.mos_en)
                ? ch_decode(diag_reg.cur_ch) : '0;
            o_analog_monitor_output_oe <= diag_reg.analog_monitor_output_en;
            o_analog_monitor_select <=
                ch_decode(diag_reg.mon_ch);
            o_analog_monitor_calibrate <= diag_reg.cal;
        end
    end

    // Channel state outputs
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_deploy_active <= '0;
            o_stretch_active <= '0;
            o_deploy_success <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                o_deploy_active[i] <= (st_reg[i] == CH_DEPLOY);
                o_stretch_active[i] <= (st_reg[i] == CH_STRETCH);
            end
            o_deploy_success <= succ_reg;
        end
    end

endmodule // sqd_decoder
`default_nettype wire

/* test/sqd_decoder_chk.sv */
// Checker for the deploy command decoder, core clock domain only.
// Assumes i_sys_rst is asynchronous and active high.
`default_nettype none
module sqd_decoder_chk
    import sqd_pkg::*;
#(
    parameter int NCH = 8,
    parameter int NACH = 4,
    parameter int DEPLOY_CYCLES = DEPLOY_CYC
)(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Channel state
    input wire logic [NCH-1:0] o_deploy_active,
    input wire logic [NCH-1:0] o_stretch_active,
    input wire logic [NCH-1:0] o_deploy_success,
    // Diagnostic switches and currents
    input wire logic [NACH-1:0] o_low_side_switch,
    input wire logic [NACH-1:0] o_high_side_switch,
    input wire logic [NACH-1:0] o_bias_current,
    input wire logic [NACH-1:0] o_resistance_source_current,
    input wire logic [NACH-1:0] o_resistance_sink_current,
    // Monitor routing
    input wire logic o_analog_monitor_output_oe,
    input wire logic [NACH-1:0] o_analog_monitor_select
);
    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Cycles channel 0 has spent deploying; a counter, since the
    // deploy period is far too long for a repetition
    logic [31:0] dep_len_reg;
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            dep_len_reg <= '0;
        else if (o_deploy_active[0])
            dep_len_reg <= dep_len_reg + 32'h1;
        else
            dep_len_reg <= '0;
    end
    dep_len_a: assert property (
        $fell(o_deploy_active[0]) |-> dep_len_reg == DEPLOY_CYCLES)
        else $error("deployment length wrong");
    no_abort_a: assert property (
        $rose(o_deploy_active[0]) |-> o_deploy_active[0] [*8])
        else $error("deployment cut short");
    done_flag_a: assert property (
        $fell(o_deploy_active[0]) |-> ##[0:2] o_deploy_success[0])
        else $error("success flag not set after deployment");
    flag_block_a: assert property (
        !(|($past(o_deploy_success) & o_deploy_active
            & ~$past(o_deploy_active))))
        else $error("deployment started over success flag");
    dep_excl_a: assert property (
        (o_deploy_active & o_stretch_active) == '0)
        else $error("deploy and stretch together");
    src_sink_a: assert property (
        o_resistance_source_current == o_resistance_sink_current)
        else $error("source and sink currents differ");
    src_mos_a: assert property (
        |o_resistance_source_current |->
            !(|{o_low_side_switch, o_high_side_switch}))
        else $error("resistance current during switch test");
    one_cur_a: assert property (
        $onehot0({o_bias_current, o_resistance_source_current}))
        else $error("more than one current source on");
    one_mon_a: assert property (
        $onehot(o_analog_monitor_select))
        else $error("monitor select not one channel");
    mos_side_a: assert property (
        $onehot0({o_low_side_switch, o_high_side_switch}))
        else $error("both switch sides on");
    // Main scenarios
    dep_c: cover property ($rose(o_deploy_active[0]));
    str_c: cover property ($rose(o_stretch_active[1]));
    src_c: cover property ($rose(|o_resistance_source_current));
    oe_c: cover property ($rose(o_analog_monitor_output_oe));
endmodule // sqd_decoder_chk
bind sqd_decoder sqd_decoder_chk #(
    .NCH(NCH), .NACH(NACH), .DEPLOY_CYCLES(DEPLOY_CYCLES)
) i_sqd_decoder_chk (
    .i_core_clk, .i_sys_rst, .o_deploy_active, .o_stretch_active,
    .o_deploy_success, .o_low_side_switch, .o_high_side_switch,
    .o_bias_current, .o_resistance_source_current,
    .o_resistance_sink_current, .o_analog_monitor_output_oe,
    .o_analog_monitor_select
);
`default_nettype wire

/* test/sqd_host.sv */
// Host model: serial master of the deployment link.
// Assumes the device samples on falling clock edges, MSB first.
`default_nettype none
module sqd_host (
    // Link to the device
    output var logic o_sclk,
    output var logic o_cs_n,
    output var logic o_mosi,
    // Reply from the device
    input wire logic i_miso
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idle: clock still and low, deselected
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // One whole frame of 48 ns bits; bad spoils the parity on purpose
    task automatic msg(input logic [15:0] w, input bit bad,
                       output logic [15:0] rsp);
        logic [15:0] f;
        f = w;
        f[13] = ~(^{w[15:14], w[12:0]}) ^ bad;
        o_cs_n = 1'b0;
        #24;
        for (int i = 15; i >= 0; i--)
        begin
            o_sclk = 1'b1;
            o_mosi = f[i];
            #24;
            o_sclk = 1'b0;
            rsp[i] = i_miso;
            #24;
        end
        o_cs_n = 1'b1;
        // Released line must not keep showing the last bit
        o_mosi = ~f[0];
        // Gap lets the core act before the next frame
        #200;
    endtask
endmodule // sqd_host
`default_nettype wire

/* test/squib_deploy_spi_command_decoder_tb.sv */
// Testbench for the deploy command decoder, driven through the host.
// Assumes short deploy and stretch periods set by parameter.
`default_nettype none
module squib_deploy_spi_command_decoder_tb;
    import sqd_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int DCY = 600;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_deploy_enable = 1'b0;
    logic [3:0] i_battery_short_threshold = 4'h4;
    logic [3:0] i_ground_short_threshold = 4'h4;
    wire logic i_spi_sclk, i_cs_n, i_mosi, o_miso;
    logic [7:0] o_deploy_active, o_stretch_active, o_deploy_success;
    logic [3:0] o_low_side_switch, o_high_side_switch, o_bias_current;
    logic [3:0] o_resistance_source_current, o_resistance_sink_current;
    logic [3:0] o_analog_monitor_select;
    logic o_analog_monitor_output_oe, o_analog_monitor_calibrate;
    logic [15:0] rsp;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    always #5 i_core_clk = ~i_core_clk;
    // A single device on the host link
    sqd_decoder #(.DEPLOY_CYCLES(DCY), .STRETCH_CYCLES(2000))
        i_sqd_decoder (
        .i_core_clk, .i_sys_rst, .i_spi_sclk, .i_cs_n, .i_mosi, .o_miso,
        .i_deploy_enable, .i_battery_short_threshold,
        .i_ground_short_threshold, .o_deploy_active, .o_stretch_active,
        .o_deploy_success, .o_low_side_switch, .o_high_side_switch,
        .o_bias_current, .o_resistance_source_current,
        .o_resistance_sink_current, .o_analog_monitor_output_oe,
        .o_analog_monitor_select, .o_analog_monitor_calibrate
    );
    sqd_host i_sqd_host (.o_sclk(i_spi_sclk), .o_cs_n(i_cs_n),
        .o_mosi(i_mosi), .i_miso(o_miso));
    task automatic finish_test;
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // One frame; rsp gets the reply to the previous one
    task automatic tx(input logic [15:0] w, input bit bad = 1'b0);
        i_sqd_host.msg(w, bad, rsp);
    endtask
    // Bounded wait for every deployment to end
    task automatic wait_idle;
        for (int k = 0; k < 800 && o_deploy_active !== 8'h00; k++)
            @(posedge i_core_clk);
        #1;
    endtask
    // Cut a hang short
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            finish_test();
        end
    end
    initial
    begin
        repeat (16) @(posedge i_core_clk);
        #1 i_sys_rst = 1'b0;
        repeat (4) @(posedge i_core_clk);
        // Diagnostic: resistance current ch3, monitor ch2, calibrate
        tx(16'h93AB);
        chk("first reply", 16'h0000, rsp);
        chk("source", 16'h0008, o_resistance_source_current);
        chk("sink", 16'h0008, o_resistance_sink_current);
        chk("bias", 16'h0000, o_bias_current);
        chk("monitor", 16'h0034, {10'h0, o_analog_monitor_output_oe,
            o_analog_monitor_calibrate, o_analog_monitor_select});
        // Switch test high side ch1 blocks resistance current
        tx(16'h9F01);
        chk("diag reply", 16'h0015, {rsp[15:12], rsp[9]});
        chk("source", 16'h0000, o_resistance_source_current);
        chk("high", 16'h0002, o_high_side_switch);
        chk("low", 16'h0000, o_low_side_switch);
        chk("monitor", 16'h0001, {10'h0, o_analog_monitor_output_oe,
            o_analog_monitor_calibrate, o_analog_monitor_select});
        // Read leaves settings alone but still replies
        tx(16'h8A07);
        chk("high", 16'h0002, o_high_side_switch);
        tx(16'h9204);
        chk("read reply", 16'h0002, rsp[15:14]);
        chk("bias", 16'h0000, o_bias_current);
        chk("high", 16'h0000, o_high_side_switch);
        tx(16'h9200);
        chk("bias", 16'h0001, o_bias_current);
        // Spoiled parity is not executed, fault reply follows
        tx(16'h93AB, 1'b1);
        chk("bias", 16'h0001, o_bias_current);
        chk("source", 16'h0000, o_resistance_source_current);
        tx(16'h2000);
        chk("fault reply", 16'hE000, rsp);
        tx(16'h4000);
        chk("register reply", 16'h0000, rsp);
        // Stretch timer start with ignored high bits, then stop
        tx(16'h5F02);
        chk("cmd reply", 16'h0001, rsp[15:14]);
        chk("stretch", 16'h0002, o_stretch_active);
        chk("deploy", 16'h0000, o_deploy_active);
        tx(16'h4000);
        chk("stretch", 16'h0000, o_stretch_active);
        // Deployment cannot be stopped and ends with success flag
        @(posedge i_core_clk);
        #1 i_deploy_enable = 1'b1;
        tx(16'h4081);
        chk("deploy", 16'h0081, o_deploy_active);
        tx(16'h4000);
        chk("deploy", 16'h0081, o_deploy_active);
        wait_idle();
        chk("success", 16'h0081, o_deploy_success);
        tx(16'h4001);
        chk("deploy", 16'h0000, o_deploy_active);
        tx(16'h4002);
        chk("deploy", 16'h0002, o_deploy_active);
        // Status report selection while ch1 deploys
        tx(16'hC100);
        tx(16'hC000);
        chk("or status", 16'h0063, {rsp[15:13], rsp[3:0]});
        tx(16'hDEF3);
        chk("flag status", 16'h0061, {rsp[15:13], rsp[3:0]});
        chk("success", 16'h0080, o_deploy_success);
        wait_idle();
        chk("success", 16'h0082, o_deploy_success);
        tx(16'hC100);
        chk("cleared status", 16'h0060, {rsp[15:13], rsp[3:0]});
        tx(16'hC001);
        chk("or status", 16'h0062, {rsp[15:13], rsp[3:0]});
        chk("success", 16'h0082, o_deploy_success);
        finish_test();
    end
endmodule // squib_deploy_spi_command_decoder_tb
`default_nettype wire
